// ---- shared/port_hs_pkg.sv ----
// constants and types shared by the clocked handshake port
package port_hs_pkg;
    // ============================================================
    // sizes
    localparam int unsigned PORT_WIDTH  = 8;  // data pins of the buffered port
    localparam int unsigned PWIDTH_BITS = 6;  // width code of an attached ready port
    localparam logic [5:0]  READY_WIDTH = 6'h01; // a ready port must be exactly one bit

    // ============================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS  = 10;  // system clock period
    localparam int unsigned PORT_CLK_NS    = 40;  // period of the port clock block
    localparam int unsigned HALF_CYCLES    = PORT_CLK_NS / (2 * CLK_PERIOD_NS);
    localparam int unsigned DIV_BITS       = 4;
    localparam logic [3:0]  DIV_LAST       = 4'(HALF_CYCLES - 1);

    // ============================================================
    // reset values
    localparam logic [7:0] PINS_RESET = 8'h00;

    // ============================================================
    // qualification modes of the port
    typedef enum logic [1:0] {
        MODE_PLAIN     = 2'b00,
        MODE_HANDSHAKE = 2'b01,
        MODE_MASTER    = 2'b10,
        MODE_SLAVE     = 2'b11
    } mode_t;
endpackage : port_hs_pkg

// ---- rtl/port_hs.sv ----
// buffered clocked port with handshake, strobed master and strobed slave qualification
// Notes on behaviour
// RQ1: running clock block gives rising and falling edges
// RQ2: handshake mode faults unless both ready ports one-bit
// RQ3: ready-out-only modes fault unless ready-out one-bit
// RQ4: buffered input raises ready-out on fall when space
// RQ5: handshake input captures only with both readies high
// RQ6: sampling edge is rising by default, configurable
// RQ7: sample delay mode samples on falling edge
// RQ8: outputs hold initial value until first output
// RQ9: handshake output samples ready-in on sampling edge
// RQ10: handshake output launches only after sampled ready-in high
// RQ11: ready-out high on launching fall, else low
// RQ12: strobed master input captures after own ready-out
// RQ13: strobed master output launches on next fall
// RQ14: strobed slave input captures while ready-in high
// RQ15: strobed slave input faults unless ready-in one-bit
// RQ16: strobed slave output launches after sampled ready-in high
// RQ17: exceptions are sticky flags until acknowledged
`timescale 1ns/1ps
`default_nettype none
module port_hs
    import port_hs_pkg::*;
(
    // clock and reset
    input  wire logic                   i_clock,
    input  wire logic                   i_rst,
    // configuration, applied by the load pulse; run and exception acknowledge act at once
    input  wire logic                   i_run,
    input  wire logic                   i_cfg_load,
    input  wire logic [1:0]             i_cfg_mode,
    input  wire logic                   i_cfg_output,
    input  wire logic                   i_cfg_sample_delay,
    input  wire logic [PWIDTH_BITS-1:0] i_cfg_rdy_in_width,
    input  wire logic [PWIDTH_BITS-1:0] i_cfg_rdy_out_width,
    input  wire logic [PORT_WIDTH-1:0]  i_cfg_initial,
    input  wire logic                   i_exc_ack,
    // software data side
    input  wire logic                   i_tx_valid,
    input  wire logic [PORT_WIDTH-1:0]  i_tx_data,
    output logic                        o_tx_ready,
    output logic                        o_rx_valid,
    output logic [PORT_WIDTH-1:0]       o_rx_data,
    input  wire logic                   i_rx_ready,
    // pins
    input  wire logic [PORT_WIDTH-1:0]  i_pins,
    output logic [PORT_WIDTH-1:0]       o_pins,
    output logic                        o_pins_oe,
    input  wire logic                   i_ready_in,
    output logic                        o_ready_out,
    output logic                        o_port_clk,
    // status
    output logic                        o_exception
);

    // ============================================================
    // configuration, port clock, buffer and flag state
    mode_t                 mode_reg;
    logic                  out_reg;
    logic                  sdelay_reg;
    logic [DIV_BITS-1:0]   div_reg;
    logic                  pclk_reg;
    logic                  rx_full_reg;
    logic [PORT_WIDTH-1:0] rx_data_reg;
    logic                  tx_pend_reg;
    logic                  tx_free_reg;
    logic [PORT_WIDTH-1:0] tx_data_reg;
    logic                  rdy_smp_reg;
    logic                  rdy_out_reg;
    logic [PORT_WIDTH-1:0] pins_reg;
    logic                  oe_reg;
    logic                  exc_reg;
    logic                  cfg_bad;

    // a new configuration replaces the running one as a whole
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            mode_reg   <= MODE_PLAIN;
            out_reg    <= 1'b0;
            sdelay_reg <= 1'b0;
        end else if (i_cfg_load) begin
            mode_reg   <= mode_t'(i_cfg_mode);
            out_reg    <= i_cfg_output;
            sdelay_reg <= i_cfg_sample_delay;
        end
    end

    // ============================================================
    // port clock block: divider with edge enables
    logic rise_en;
    logic fall_en;
    logic sample_en;
    assign rise_en   = i_run && (div_reg == DIV_LAST) && !pclk_reg; // [RQ1]
    assign fall_en   = i_run && (div_reg == DIV_LAST) && pclk_reg;  // [RQ1]
    assign sample_en = sdelay_reg ? fall_en : rise_en;              // [RQ6] [RQ7]

    // the clock stands still while stopped, so no edge is given outside running
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div_reg  <= '0;
            pclk_reg <= 1'b0;
        end else if (i_run) begin
            if (div_reg == DIV_LAST) begin
                div_reg  <= '0;
                pclk_reg <= !pclk_reg; // [RQ1]
            end else begin
                div_reg <= div_reg + 4'h1;
            end
        end
    end

    // ============================================================
    // configuration exception checks
    always_comb begin
        cfg_bad = 1'b0;
        case (mode_t'(i_cfg_mode))
            MODE_HANDSHAKE: cfg_bad = (i_cfg_rdy_in_width != READY_WIDTH)
                                   || (i_cfg_rdy_out_width != READY_WIDTH); // [RQ2]
            MODE_MASTER:    cfg_bad = (i_cfg_rdy_out_width != READY_WIDTH); // [RQ3]
            MODE_SLAVE:     cfg_bad = !i_cfg_output
                                   && (i_cfg_rdy_in_width != READY_WIDTH);  // [RQ15]
            default:        cfg_bad = 1'b0;
        endcase
    end

    // sticky flag; a fault in the acknowledge cycle still sets it
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst)
            exc_reg <= 1'b0;
        else if (i_cfg_load && cfg_bad)
            exc_reg <= 1'b1; // [RQ17]
        else if (i_exc_ack)
            exc_reg <= 1'b0; // [RQ17]
    end

    // ============================================================
    // input path: one-word receive buffer
    logic capture;
    logic rx_drain;
    assign rx_drain = rx_full_reg && i_rx_ready;
    always_comb begin
        capture = 1'b0;
        if (!out_reg && sample_en) begin
            case (mode_reg)
                MODE_HANDSHAKE: capture = i_ready_in && rdy_out_reg; // [RQ5]
                MODE_MASTER:    capture = rdy_out_reg;               // [RQ12]
                MODE_SLAVE:     capture = i_ready_in;                // [RQ14]
                default:        capture = 1'b0;
            endcase
        end
    end

    // a slave capture into a full buffer is dropped rather than overwrite unread data
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            rx_full_reg <= 1'b0;
            rx_data_reg <= PINS_RESET;
        end else if (i_cfg_load) begin
            rx_full_reg <= 1'b0;
        end else if (capture && (!rx_full_reg || rx_drain)) begin
            rx_full_reg <= 1'b1;
            rx_data_reg <= i_pins;
        end else if (rx_drain) begin
            rx_full_reg <= 1'b0;
        end
    end

    // ============================================================
    // output path: one pending word
    logic launch;
    always_comb begin
        launch = 1'b0;
        if (out_reg && fall_en && tx_pend_reg) begin
            case (mode_reg)
                MODE_HANDSHAKE: launch = rdy_smp_reg; // [RQ10]
                MODE_MASTER:    launch = 1'b1;        // [RQ13]
                MODE_SLAVE:     launch = rdy_smp_reg; // [RQ16]
                default:        launch = 1'b1;
            endcase
        end
    end

    // the free flag is its own flop so the ready output needs no inverter behind it
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            tx_pend_reg <= 1'b0;
            tx_free_reg <= 1'b1;
            tx_data_reg <= PINS_RESET;
        end else if (i_cfg_load || launch) begin
            tx_pend_reg <= 1'b0;
            tx_free_reg <= 1'b1;
        end else if (i_tx_valid && !tx_pend_reg) begin
            tx_pend_reg <= 1'b1;
            tx_free_reg <= 1'b0;
            tx_data_reg <= i_tx_data;
        end
    end

    // ready-in is sampled on the sampling edge, used at the next fall
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst)
            rdy_smp_reg <= 1'b0;
        else if (i_cfg_load)
            rdy_smp_reg <= 1'b0;
        else if (sample_en)
            rdy_smp_reg <= i_ready_in; // [RQ9]
    end

    // pins keep the initial value until the first launch replaces it
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pins_reg <= PINS_RESET;
            oe_reg   <= 1'b0;
        end else if (i_cfg_load) begin
            pins_reg <= i_cfg_initial; // [RQ8]
            oe_reg   <= i_cfg_output;
        end else if (launch) begin
            pins_reg <= tx_data_reg;   // [RQ8]
        end
    end

    // ready-out only ever moves on a falling edge of the port clock or on a load, which clears it;
    // a capture on that same edge fills the buffer, so it withholds ready-out
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst)
            rdy_out_reg <= 1'b0;
        else if (i_cfg_load)
            rdy_out_reg <= 1'b0;
        else if (fall_en) begin
            if (mode_reg == MODE_HANDSHAKE || mode_reg == MODE_MASTER)
                rdy_out_reg <= out_reg ? launch                          // [RQ11]
                                       : (!capture && (!rx_full_reg || rx_drain)); // [RQ4]
            else
                rdy_out_reg <= 1'b0;
        end
    end

    // ============================================================
    // outputs straight from flip-flops
    assign o_tx_ready  = tx_free_reg;
    assign o_rx_valid  = rx_full_reg;
    assign o_rx_data   = rx_data_reg;
    assign o_pins      = pins_reg;
    assign o_pins_oe   = oe_reg;
    assign o_ready_out = rdy_out_reg;
    assign o_port_clk  = pclk_reg;
    assign o_exception = exc_reg;

    // ============================================================
    // checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    clk_stop_a:   assert property (!i_run |=> $stable(o_port_clk)) // [RQ1]
        else $error("port clock moved while stopped");
    hs_fault_a:   assert property (i_cfg_load && i_cfg_mode == MODE_HANDSHAKE // [RQ2]
        && (i_cfg_rdy_in_width != READY_WIDTH || i_cfg_rdy_out_width != READY_WIDTH) |=> o_exception)
        else $error("handshake width fault missed");
    ms_fault_a:   assert property (i_cfg_load && i_cfg_mode == MODE_MASTER // [RQ3]
        && i_cfg_rdy_out_width != READY_WIDTH |=> o_exception)
        else $error("master width fault missed");
    ss_fault_a:   assert property (i_cfg_load && i_cfg_mode == MODE_SLAVE && !i_cfg_output // [RQ15]
        && i_cfg_rdy_in_width != READY_WIDTH |=> o_exception)
        else $error("slave width fault missed");
    exc_hold_a:   assert property (o_exception && !i_exc_ack && !i_cfg_load |=> o_exception) // [RQ17]
        else $error("exception flag lost");
    rdy_fall_a:   assert property ($changed(o_ready_out) && !$past(i_cfg_load) |-> $past(fall_en)) // [RQ4] [RQ11]
        else $error("ready-out moved off a falling edge");
    in_space_a:   assert property (fall_en && !out_reg && mode_reg == MODE_MASTER // [RQ4]
        && !rx_full_reg && !capture && !i_cfg_load |=> o_ready_out)
        else $error("ready-out not raised with space");
    hs_cap_a:     assert property (!out_reg && mode_reg == MODE_HANDSHAKE && !i_cfg_load // [RQ5]
        && !rx_full_reg && $rose(o_rx_valid) == 1'b0 ##1 $rose(o_rx_valid)
        |-> $past(i_ready_in) && $past(o_ready_out) && $past(sample_en))
        else $error("handshake capture without both readies");
    pin_launch_a: assert property ($changed(o_pins) && !$past(i_cfg_load) |-> $past(fall_en) // [RQ10] [RQ13] [RQ16]
        && $past(tx_pend_reg) && ($past(mode_reg) inside {MODE_MASTER, MODE_PLAIN} || $past(rdy_smp_reg)))
        else $error("pins changed without a legal launch");
    out_rdy_a:    assert property (fall_en && out_reg && tx_pend_reg && mode_reg == MODE_MASTER // [RQ11] [RQ13]
        && !i_cfg_load |=> o_ready_out && o_tx_ready)
        else $error("master launch missing strobe");

    hs_out_c:  cover property (out_reg && mode_reg == MODE_HANDSHAKE && launch);
    ms_in_c:   cover property (!out_reg && mode_reg == MODE_MASTER && capture);
    ss_in_c:   cover property (!out_reg && mode_reg == MODE_SLAVE && sdelay_reg && capture);
    exc_c:     cover property (i_cfg_load && cfg_bad && i_exc_ack);
endmodule : port_hs
`default_nettype wire

// ---- dv/port_peer.sv ----
// far-side peripheral model: ready strobe and pin data
`timescale 1ns/1ps
`default_nettype none
module port_peer
    import port_hs_pkg::*;
(
    // control from the bench
    input  wire logic                  i_accept,
    input  wire logic                  i_send,
    input  wire logic [PORT_WIDTH-1:0] i_word,
    // toward the port
    output logic                       o_ready_in,
    output logic [PORT_WIDTH-1:0]      o_pins
);
    // ========================================
    // strobe and data
    // follows the bench controls, so it moves with the same small delay after the edge;
    // idle pins carry the inverse word so stale data can never match
    assign o_ready_in = i_accept | i_send;
    assign o_pins     = i_send ? i_word : ~i_word;
endmodule : port_peer
`default_nettype wire

// ---- dv/port_hs_tb_top.sv ----
// self-checking bench for the clocked handshake port
`timescale 1ns/1ps
`default_nettype none
module port_hs_tb_top;
    import port_hs_pkg::*;
    // ========================================
    // signals
    logic       i_clock, i_rst, i_run, i_cfg_load, i_cfg_output, i_cfg_sample_delay;
    logic       i_exc_ack, i_tx_valid, o_tx_ready, o_rx_valid, i_rx_ready, o_pins_oe;
    logic       i_ready_in, o_ready_out, o_port_clk, o_exception, accept, send;
    logic [1:0] i_cfg_mode;
    logic [5:0] i_cfg_rdy_in_width, i_cfg_rdy_out_width;
    logic [7:0] i_cfg_initial, i_tx_data, o_rx_data, i_pins, o_pins, word;
    int         n_fail, compares;

    port_hs i_port_hs (.i_clock, .i_rst, .i_run, .i_cfg_load, .i_cfg_mode, .i_cfg_output,
        .i_cfg_sample_delay, .i_cfg_rdy_in_width, .i_cfg_rdy_out_width, .i_cfg_initial,
        .i_exc_ack, .i_tx_valid, .i_tx_data, .o_tx_ready, .o_rx_valid, .o_rx_data,
        .i_rx_ready, .i_pins, .o_pins, .o_pins_oe, .i_ready_in, .o_ready_out,
        .o_port_clk, .o_exception);
    port_peer i_port_peer (.i_accept(accept), .i_send(send), .i_word(word),
        .o_ready_in(i_ready_in), .o_pins(i_pins));

    // ========================================
    // helpers
    task automatic step(int n = 1);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : step

    task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // one load pulse, then the config answer one cycle later
    task automatic load(logic [1:0] m, logic out, logic dly, logic [5:0] wi, logic [5:0] wo,
                        logic [7:0] init, logic exc);
        i_cfg_mode = m;
        i_cfg_output = out;
        i_cfg_sample_delay = dly;
        i_cfg_rdy_in_width = wi;
        i_cfg_rdy_out_width = wo;
        i_cfg_initial = init;
        i_cfg_load = 1'b1;
        step();
        i_cfg_load = 1'b0;
        chk("exception", {7'h00, o_exception}, {7'h00, exc});
        chk("pins_oe", {7'h00, o_pins_oe}, {7'h00, out});
    endtask : load

    // ========================================
    // scenarios
    // the acknowledge is already high at the load: the fault must still win
    task automatic fault_case(logic [1:0] m, logic out, logic [5:0] wi, logic [5:0] wo);
        i_exc_ack = 1'b1;
        load(m, out, 1'b0, wi, wo, 8'h00, 1'b1);
        i_exc_ack = 1'b0;
        step(3);
        chk("exc_sticky", {7'h00, o_exception}, 8'h01);
        i_exc_ack = 1'b1;
        step();
        chk("exc_cleared", {7'h00, o_exception}, 8'h00);
    endtask : fault_case

    task automatic tx_case(logic [1:0] m, logic gated, logic ro);
        load(m, 1'b1, 1'b0, 6'h01, 6'h01, 8'hA5, 1'b0);
        chk("pins_init", o_pins, 8'hA5);
        i_tx_valid = 1'b1;
        i_tx_data = 8'h3C;
        step();
        i_tx_valid = 1'b0;
        chk("tx_busy", {7'h00, o_tx_ready}, 8'h00);
        if (gated) begin
            step(12);
            chk("pins_held", o_pins, 8'hA5);
            accept = 1'b1;
        end
        for (int i = 0; i < 20 && o_tx_ready !== 1'b1; i++) step();
        chk("tx_free", {7'h00, o_tx_ready}, 8'h01);
        chk("pins_word", o_pins, 8'h3C);
        chk("rdy_launch", {7'h00, o_ready_out}, {7'h00, ro});
        accept = 1'b0;
        step(4);
        chk("rdy_idle", {7'h00, o_ready_out}, 8'h00);
    endtask : tx_case

    // no capture while the qualifier is missing, then one word, then a full buffer
    task automatic rx_case(logic [1:0] m, logic dly, logic gated, logic ro);
        load(m, 1'b0, dly, 6'h01, 6'h01, 8'h00, 1'b0);
        word = 8'h5A;
        send = !gated;
        if (gated) begin
            step(12);
            chk("rx_none", {7'h00, o_rx_valid}, 8'h00);
            chk("rdy_empty", {7'h00, o_ready_out}, {7'h00, ro});
            send = 1'b1;
        end
        for (int i = 0; i < 20 && o_rx_valid !== 1'b1; i++) step();
        send = 1'b0;
        chk("rx_valid", {7'h00, o_rx_valid}, 8'h01);
        // the port clock has just risen on a rising sample, just fallen on a delayed one
        chk("rx_edge", {7'h00, o_port_clk}, {7'h00, !dly});
        chk("rx_data", o_rx_data, 8'h5A);
        step(4);
        chk("rdy_full", {7'h00, o_ready_out}, 8'h00);
        i_rx_ready = 1'b1;
        step();
        i_rx_ready = 1'b0;
        chk("rx_drained", {7'h00, o_rx_valid}, 8'h00);
    endtask : rx_case

    // the port clock stands still while stopped and keeps its half period after
    task automatic clk_case();
        logic held;
        held = o_port_clk;
        i_run = 1'b0;
        step(6);
        chk("pclk_stopped", {7'h00, o_port_clk}, {7'h00, held});
        i_run = 1'b1;
        for (int i = 0; i < 8 && o_port_clk === held; i++) step();
        chk("pclk_moved", {7'h00, o_port_clk}, {7'h00, !held});
        step(int'(HALF_CYCLES));
        chk("pclk_half", {7'h00, o_port_clk}, {7'h00, held});
    endtask : clk_case

    task automatic final_report();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    // ========================================
    // clock, sequence and watchdog
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    initial begin
        {i_cfg_load, i_cfg_mode, i_cfg_output, i_cfg_sample_delay, i_exc_ack} = '0;
        {i_cfg_rdy_in_width, i_cfg_rdy_out_width, i_cfg_initial} = '0;
        {i_tx_valid, i_tx_data, i_rx_ready, accept, send, word} = '0;
        n_fail = 0;
        compares = 0;
        i_run = 1'b1;
        i_rst = 1'b1;
        step(8);
        i_rst = 1'b0;
        chk("rst_tx_ready", {7'h00, o_tx_ready}, 8'h01);
        chk("rst_pins", o_pins, PINS_RESET);
        fault_case(MODE_HANDSHAKE, 1'b0, 6'h02, 6'h01);
        fault_case(MODE_MASTER, 1'b1, 6'h01, 6'h00);
        fault_case(MODE_SLAVE, 1'b0, 6'h03, 6'h01);
        i_exc_ack = 1'b0;
        tx_case(MODE_HANDSHAKE, 1'b1, 1'b1);
        tx_case(MODE_MASTER, 1'b0, 1'b1);
        tx_case(MODE_SLAVE, 1'b1, 1'b0);
        rx_case(MODE_HANDSHAKE, 1'b0, 1'b1, 1'b1);
        rx_case(MODE_MASTER, 1'b0, 1'b0, 1'b1);
        rx_case(MODE_SLAVE, 1'b1, 1'b1, 1'b0);
        clk_case();
        final_report();
    end

    // the sequence needs well under 1000 cycles; this span is generous
    initial begin
        #200000;
        n_fail++;
        final_report();
    end
endmodule : port_hs_tb_top
`default_nettype wire
